// >>> logic/cbt_pkg.sv
// Package of register offsets, field positions and timing constants for the bit-timing block.
package cbt_pkg;
   // ****************************************
   // Register byte addresses
   // ****************************************
   // The second timing register's offset is given as a word index; each register is one word of four bytes.
   localparam int IDX_BTR1 = 3;
   localparam logic [7:0] OFS_BTR0 = 8'h00;
   localparam logic [7:0] OFS_BTR1 = 8'(4 * IDX_BTR1);
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_EN = 8'h18;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int BTR1_TRIPLE_SAMPLE_SEL = 7;
   localparam int CTRL_INIT_REQUEST = 0;
   localparam int CTRL_SLEEP_REQUEST = 1;
   localparam int CTRL_ENABLE = 2;
   localparam int CTRL_WAITSTOP = 3;
   localparam int STAT_INIT_ACKNOWLEDGE = 0;
   localparam int STAT_SLEEP_ACKNOWLEDGE = 1;
   localparam int IRQ_INIT = 0;
   localparam int IRQ_SLEEP = 1;
   localparam int IRQ_W = 2;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] BTR0_RST = 8'h00;
   localparam logic [7:0] BTR1_RST = 8'h00;
   localparam logic [3:0] CTRL_RST = 4'h5;
   // ****************************************
   // Synchronisation depths (CAN side in CAN-domain enables, bus side in clock cycles)
   // ****************************************
   localparam int CAN_SYNC_STAGES = 3;
   localparam int BUS_SYNC_STAGES = 2;
   localparam int CLK_HZ = 10000000;
   localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
endpackage

// >>> logic/cbt_sync.sv
// Shift-register synchroniser used to carry a level into a clock-enabled domain.
`timescale 1ns/1ps
module cbt_sync #(
   parameter int STAGES = 2
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Stage advance enable
   input wire logic adv,
   // Level in and out
   input wire logic din,
   output logic dout
);
   logic [STAGES-1:0] chain;

   // A single stage would let logic read a possibly metastable flop.
   if (STAGES < 2) begin : g_bad_stages
      $error("cbt_sync needs at least two stages");
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chain <= '0;
      end else if (adv) begin
         chain <= {chain[STAGES-2:0], din};
      end
   end

   assign dout = chain[STAGES-1];
endmodule

// >>> logic/cbt_top.sv
// Bit timing, initialization handshake and low-power gating of a CAN controller.
`timescale 1ns/1ps
module cbt_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // CAN receive pin and recovered bit
   input wire logic can_rx,
   output logic rx_bit,
   output logic rx_bit_valid,
   // Power and clock gates, interrupt
   output logic can_clk_en,
   output logic reg_clk_en,
   input wire logic cpu_wait,
   output logic irq
);
   // ****************************************
   // Bus slave
   // ****************************************
   logic [7:0] btr0;
   logic [7:0] btr1;
   logic init_request;
   logic sleep_request;
   logic module_enable;
   logic wait_clock_stop;
   logic init_acknowledge;
   logic sleep_acknowledge;
   logic [1:0] irq_stat;
   logic [1:0] irq_en;
   logic ph_wr;
   logic ph_rd;
   logic [7:0] ph_addr;
   logic tq_tick;

   wire logic take = hsel && hready && htrans[1];
   wire logic init_mode = init_request && init_acknowledge;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr <= 1'b0;
         ph_rd <= 1'b0;
         ph_addr <= 8'h00;
      end else if (hready) begin
         ph_wr <= take && hwrite;
         ph_rd <= take && !hwrite;
         ph_addr <= haddr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         btr0 <= cbt_pkg::BTR0_RST;
         btr1 <= cbt_pkg::BTR1_RST;
      end else if (ph_wr && init_mode) begin
         if (ph_addr == cbt_pkg::OFS_BTR0) begin
            btr0 <= hwdata[7:0];
         end
         if (ph_addr == cbt_pkg::OFS_BTR1) begin
            btr1 <= hwdata[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {wait_clock_stop, module_enable, sleep_request, init_request} <= cbt_pkg::CTRL_RST;
      end else if (ph_wr && ph_addr == cbt_pkg::OFS_CTRL) begin
         module_enable <= hwdata[cbt_pkg::CTRL_ENABLE];
         wait_clock_stop <= hwdata[cbt_pkg::CTRL_WAITSTOP];
         sleep_request <= hwdata[cbt_pkg::CTRL_SLEEP_REQUEST];
         // Clearing the request is ignored until the acknowledge is back.
         if (hwdata[cbt_pkg::CTRL_INIT_REQUEST] || init_mode) begin
            init_request <= hwdata[cbt_pkg::CTRL_INIT_REQUEST];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else begin
         hrdata <= 32'h00000000;
         if (take && !hwrite) begin
            unique case (haddr)
               cbt_pkg::OFS_BTR0: hrdata[7:0] <= btr0;
               cbt_pkg::OFS_BTR1: hrdata[7:0] <= btr1;
               cbt_pkg::OFS_CTRL: hrdata[3:0] <= {wait_clock_stop, module_enable,
                                                  sleep_request, init_request};
               cbt_pkg::OFS_STAT: hrdata[1:0] <= {sleep_acknowledge, init_acknowledge};
               cbt_pkg::OFS_IRQ_STAT: hrdata[1:0] <= irq_stat;
               cbt_pkg::OFS_IRQ_EN: hrdata[1:0] <= irq_en;
               default: hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ****************************************
   // Clock gating
   // ****************************************
   // Sleep keeps register access alive; power-down (sleep plus wait stop while cpu_wait is high) halts all.
   wire logic low_power = module_enable && sleep_acknowledge;
   wire logic power_down = low_power && wait_clock_stop && cpu_wait;
   assign can_clk_en = module_enable && !low_power;
   assign reg_clk_en = module_enable && !power_down;

   // ****************************************
   // Prescaler
   // ****************************************
   logic [5:0] pre_cnt;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt <= 6'h00;
         tq_tick <= 1'b0;
      end else if (!can_clk_en) begin
         pre_cnt <= 6'h00;
         tq_tick <= 1'b0;
      end else if (pre_cnt >= btr0[5:0]) begin
         pre_cnt <= 6'h00;
         tq_tick <= 1'b1;
      end else begin
         pre_cnt <= pre_cnt + 6'h01;
         tq_tick <= 1'b0;
      end
   end

   // ****************************************
   // Init handshake
   // ****************************************
   logic req_bus;
   logic req_can;
   logic ack_back;

   cbt_sync #(.STAGES(cbt_pkg::CAN_SYNC_STAGES)) u_to_can (
      .hclk(hclk),
      .hresetn(hresetn),
      .adv(tq_tick || !can_clk_en),
      .din(init_request),
      .dout(req_can)
   );

   cbt_sync #(.STAGES(cbt_pkg::BUS_SYNC_STAGES)) u_to_bus (
      .hclk(hclk),
      .hresetn(hresetn),
      .adv(1'b1),
      .din(req_can),
      .dout(req_bus)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ack_back <= 1'b0;
      end else begin
         ack_back <= req_bus;
      end
   end
   assign init_acknowledge = ack_back && init_request;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_acknowledge <= 1'b0;
      end else begin
         sleep_acknowledge <= module_enable && sleep_request;
      end
   end

   // ****************************************
   // Bit timing and sampling
   // ****************************************
   logic rx_m;
   logic rx_s;
   logic [4:0] tq_cnt;
   logic [2:0] smp;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_m <= 1'b1;
         rx_s <= 1'b1;
      end else begin
         rx_m <= can_rx;
         rx_s <= rx_m;
      end
   end

   wire logic [4:0] seg1_end = 5'd1 + {1'b0, btr1[3:0]};
   wire logic [4:0] bit_last = seg1_end + {2'b00, btr1[6:4]} + 5'd1;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tq_cnt <= 5'd0;
         smp <= 3'h7;
      end else if (init_mode) begin
         tq_cnt <= 5'd0;
      end else if (tq_tick) begin
         tq_cnt <= (tq_cnt == bit_last) ? 5'd0 : tq_cnt + 5'd1;
         smp <= {smp[1:0], rx_s};
      end
   end

   function automatic logic majority(input logic [2:0] s);
      majority = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_bit <= 1'b1;
         rx_bit_valid <= 1'b0;
      end else begin
         rx_bit_valid <= 1'b0;
         if (tq_tick && !init_mode && tq_cnt == seg1_end) begin
            rx_bit_valid <= 1'b1;
            if (btr1[cbt_pkg::BTR1_TRIPLE_SAMPLE_SEL]) begin
               rx_bit <= majority({smp[1:0], rx_s});
            end else begin
               rx_bit <= rx_s;
            end
         end
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   logic ack_d;
   logic slp_d;
   wire logic [1:0] ev = {sleep_acknowledge && !slp_d, init_acknowledge && !ack_d};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ack_d <= 1'b0;
         slp_d <= 1'b0;
         irq_stat <= 2'b00;
         irq_en <= 2'b00;
      end else begin
         ack_d <= init_acknowledge;
         slp_d <= sleep_acknowledge;
         if (ph_wr && ph_addr == cbt_pkg::OFS_IRQ_EN) begin
            irq_en <= hwdata[1:0];
         end
         if (ph_wr && ph_addr == cbt_pkg::OFS_IRQ_CLR) begin
            irq_stat <= (irq_stat & ~hwdata[1:0]) | ev;
         end else begin
            irq_stat <= irq_stat | ev;
         end
      end
   end
   assign irq = |(irq_stat & irq_en);

   // ****************************************
   // Checks
   // ****************************************
   AST_BTR_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
      !init_mode |=> $stable(btr1) || $past(init_mode))
      else $error("timing register changed outside init mode");
   AST_RQ_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      (init_request && !init_acknowledge) |=> init_request)
      else $error("init request cleared before acknowledge");
   AST_ACK_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
      init_acknowledge |-> req_bus || $past(req_bus))
      else $error("acknowledge without synchronised request");
   AST_ACK_DELAY: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(init_request) |-> !init_acknowledge [*4])
      else $error("acknowledge too early");
   AST_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      !module_enable |-> !can_clk_en && !reg_clk_en)
      else $error("clocks running while disabled");
   AST_SLEEP: assert property (@(posedge hclk) disable iff (!hresetn)
      (low_power && !power_down) |-> !can_clk_en && reg_clk_en)
      else $error("sleep gating wrong");
   AST_PDOWN: assert property (@(posedge hclk) disable iff (!hresetn)
      power_down |-> !reg_clk_en)
      else $error("power down left a clock running");
   AST_SAMPLE: assert property (@(posedge hclk) disable iff (!hresetn)
      (tq_tick && !init_mode && tq_cnt == seg1_end && !btr1[cbt_pkg::BTR1_TRIPLE_SAMPLE_SEL])
      |=> rx_bit == $past(rx_s))
      else $error("single sample mismatch");
   AST_PRESC: assert property (@(posedge hclk) disable iff (!hresetn)
      (tq_tick && btr0[5:0] == 6'h01 && can_clk_en) |=> !tq_tick)
      else $error("prescaler ratio wrong");
endmodule

// >>> test/cbt_can_node.sv
// Model of another CAN node that sends one byte as long, stable bits.
`timescale 1ns/1ps
module cbt_can_node (
   // Clock
   input wire logic hclk,
   // Frame request
   input wire logic send,
   input wire logic [7:0] frame,
   input wire logic [15:0] bit_len,
   // Bus level and checking window
   output logic can_rx,
   output logic steady,
   output logic level
);
   logic act = 1'b0;
   int cnt = 0;
   int idx = 0;
   // Each bit lasts four bit times, so the samples taken after its first bit time land well inside.
   always @(posedge hclk) begin
      if (!act) begin
         act <= send;
         cnt <= 0;
         idx <= 0;
      end else if (cnt == 4 * bit_len - 1) begin
         cnt <= 0;
         idx <= idx + 1;
         act <= idx != 7;
      end else
         cnt <= cnt + 1;
   end
   // The idle bus shows the recessive level that its pull-up gives.
   assign level = act ? frame[3'(7 - idx)] : 1'b1;
   assign can_rx = level;
   assign steady = act && cnt >= bit_len + 4;
endmodule

// >>> test/test_cbt_top.sv
// Self-checking bench for bit timing, init handshake and power gating.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin failures++; \
$display("ERROR %s exp %h got %h", n, e, s); end end
module test_cbt_top;
   logic hclk = 0, hresetn = 0, hwrite = 0, cpu_wait = 0, send = 0, meas = 0, ph = 0;
   logic [1:0] htrans = 2'h0;
   logic [7:0] haddr = 8'h00, cfg;
   logic [31:0] hwdata = 32'h0, hrdata, rv, e, m;
   logic hreadyout, hresp, can_rx, rx_bit, rx_bit_valid, can_clk_en, reg_clk_en, irq;
   logic steady, level;
   logic [15:0] blen = 16'h0010;
   logic [31:0] qe[$], qm[$];
   int failures = 0, n_tests = 0, cyc = 0, last = 0, span = 0, t0, p, t1, t2;
   always #50 hclk = ~hclk;
   cbt_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .can_rx(can_rx), .rx_bit(rx_bit),
      .rx_bit_valid(rx_bit_valid), .can_clk_en(can_clk_en), .reg_clk_en(reg_clk_en),
      .cpu_wait(cpu_wait), .irq(irq));
   cbt_can_node node_u (.hclk(hclk), .send(send), .frame(8'hA5), .bit_len(blen),
      .can_rx(can_rx), .steady(steady), .level(level));
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rv = hrdata;
   endtask
   // A zero mask notes a poll read whose value is judged by the caller.
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
      qe.push_back(ex);
      qm.push_back(mk);
      xfer(a, 1'b0, 32'h0);
   endtask
   task automatic wait_ack(input logic v);
      int n = 0;
      do begin
         rd(cbt_pkg::OFS_STAT, 32'h0, 32'h0);
         n++;
      end while (rv[0] !== v && n < 100);
      `CHK("init_ack", v, rv[0])
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      ph <= htrans[1] && !hwrite && hreadyout;
      if (ph) begin
         e = qe.pop_front();
         m = qm.pop_front();
         if (m != 0) `CHK("hrdata", e & m, hrdata & m)
         `CHK("hresp", 1'b0, hresp)
      end
      if (rx_bit_valid === 1'b1) begin
         if (meas) `CHK("bit_span", span, cyc - last)
         if (meas && steady) `CHK("rx_bit", level, rx_bit)
         last <= cyc;
      end
   end
   initial begin
      #(100 * 20000);
      failures++;
      conclude();
   end
   initial begin
      rv = $urandom(23279);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t0 = cyc;
      xfer(cbt_pkg::OFS_CTRL, 1'b1, 32'h4);
      rd(cbt_pkg::OFS_CTRL, 32'h5, 32'hF);
      rd(cbt_pkg::OFS_BTR0, 32'(cbt_pkg::BTR0_RST), 32'hFF);
      rd(cbt_pkg::OFS_BTR1, 32'(cbt_pkg::BTR1_RST), 32'hFF);
      xfer(cbt_pkg::OFS_IRQ_EN, 1'b1, 32'h3);
      wait_ack(1'b1);
      `CHK("ack_delay", 1'b1, cyc - t0 >= 5)
      #1 `CHK("irq", 1'b1, irq)
      rd(cbt_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
      xfer(cbt_pkg::OFS_IRQ_CLR, 1'b1, 32'h3);
      #1 `CHK("irq", 1'b0, irq)
      rd(8'h20, 32'h0, 32'hFFFFFFFF);
      for (int s = 0; s < 2; s++) begin
         p = s * 2 + $urandom % 2;
         t1 = 1 + $urandom % 4;
         t2 = $urandom % 3;
         cfg = {s[0], t2[2:0], t1[3:0]};
         meas <= 1'b0;
         t0 = cyc;
         xfer(cbt_pkg::OFS_CTRL, 1'b1, 32'h5);
         wait_ack(1'b1);
         if (s == 1) `CHK("ack_delay", 1'b1, cyc - t0 >= 5)
         xfer(cbt_pkg::OFS_BTR0, 1'b1, 32'(p));
         xfer(cbt_pkg::OFS_BTR1, 1'b1, {24'h0, cfg});
         rd(cbt_pkg::OFS_BTR1, {24'h0, cfg}, 32'hFF);
         xfer(cbt_pkg::OFS_CTRL, 1'b1, 32'h4);
         wait_ack(1'b0);
         xfer(cbt_pkg::OFS_BTR1, 1'b1, {24'h0, ~cfg});
         rd(cbt_pkg::OFS_BTR1, {24'h0, cfg}, 32'hFF);
         span = (p + 1) * (t1 + t2 + 3);
         blen = 16'(span);
         repeat (3 * span) @(posedge hclk);
         meas <= 1'b1;
         send <= 1'b1;
         @(posedge hclk);
         send <= 1'b0;
         repeat (33 * span) @(posedge hclk);
      end
      meas <= 1'b0;
      xfer(cbt_pkg::OFS_CTRL, 1'b1, 32'h0);
      #1 `CHK("can_clk_en", 1'b0, can_clk_en)
      `CHK("reg_clk_en", 1'b0, reg_clk_en)
      xfer(cbt_pkg::OFS_CTRL, 1'b1, 32'h6);
      repeat (2) @(posedge hclk);
      #1 `CHK("can_clk_en", 1'b0, can_clk_en)
      `CHK("reg_clk_en", 1'b1, reg_clk_en)
      `CHK("irq", 1'b1, irq)
      xfer(cbt_pkg::OFS_IRQ_EN, 1'b1, 32'h0);
      #1 `CHK("irq", 1'b0, irq)
      rd(cbt_pkg::OFS_STAT, 32'h2, 32'h2);
      rd(cbt_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
      xfer(cbt_pkg::OFS_IRQ_CLR, 1'b1, 32'h3);
      xfer(cbt_pkg::OFS_IRQ_EN, 1'b1, 32'h3);
      #1 `CHK("irq", 1'b0, irq)
      cpu_wait <= 1'b1;
      xfer(cbt_pkg::OFS_CTRL, 1'b1, 32'hE);
      repeat (2) @(posedge hclk);
      #1 `CHK("reg_clk_en", 1'b0, reg_clk_en)
      `CHK("can_clk_en", 1'b0, can_clk_en)
      cpu_wait <= 1'b0;
      repeat (2) @(posedge hclk);
      #1 `CHK("reg_clk_en", 1'b1, reg_clk_en)
      conclude();
   end
endmodule
